// >>> ssac_defines.svh
// register offsets, field positions and timing counts for the sample source and arm control
`ifndef SSAC_DEFINES_SVH
`define SSAC_DEFINES_SVH
`define SSAC_REG_OFFSET      6'h3E
`define SSAC_ADDR_W          6
`define SSAC_BIT_LINE_LO     0
`define SSAC_BIT_LINE_HI     2
`define SSAC_BIT_LINE_DIR    3
`define SSAC_BIT_LINE_EN     4
`define SSAC_BIT_INT_CLOCK   5
`define SSAC_BIT_EXT_TB      6
`define SSAC_BIT_SOFT        7
`define SSAC_BIT_EDGE        8
`define SSAC_BIT_FRONT_EN    9
`define SSAC_BIT_ABORT       12
`define SSAC_BIT_ARM_DELAY   13
`define SSAC_BIT_ARM_NOW     15
`define SSAC_RESET_VALUE     16'h0000
`define SSAC_WRITE_MASK      16'hB3FF
`define SSAC_CLOCK_MHZ       100
`define SSAC_ARM_DELAY_MS    30
`define SSAC_ARM_DELAY_CYC   (`SSAC_ARM_DELAY_MS * 1000 * `SSAC_CLOCK_MHZ)
`endif

// >>> ssac_partner_model.sv
// far-side model: open-collector backplane trigger lines and front-panel sample source
`timescale 1ns/1ns
module ssac_partner_model (
   // device drive of the backplane lines
   input  wire logic [7:0] line_out,
   input  wire logic [7:0] line_oe,
   // levels seen by the device
   output logic            front_pin,
   output logic [7:0]      line_level
);
   logic [7:0] pull_low;  // lines this model holds low

   // pull-up on every line, any low driver wins the wire
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         line_level[i] = (line_oe[i] ? line_out[i] : 1'b1) & ~pull_low[i];
      end
   end

   // the source drives the pin at all times, it never floats
   initial
   begin
      pull_low  = 8'h00;
      front_pin = 1'b0;
   end

   // low pulse on one line; the device sees the rising edge at release
   task automatic line_pulse(input int idx);
      pull_low[idx] = 1'b1;
      #40;
      pull_low[idx] = 1'b0;
   endtask

   // new level on the front sample pin
   task automatic set_front(input logic v);
      front_pin = v;
   endtask
endmodule

// >>> ssac_pkg.sv
// types for the sample source and arm control
package ssac_pkg;
   // decoded control fields
   typedef struct packed {
      logic       arm_now;
      logic       arm_after_delay;
      logic       abort;
      logic       front_sample_input_enable;
      logic       sample_edge_polarity;
      logic       soft_sample_enable;
      logic       external_timebase_select;
      logic       int_clock_enable;
      logic       line_enable;
      logic       line_drive;
      logic [2:0] line_select;
   } ssac_ctrl_t;
   // acquisition sequencer states
   typedef enum logic [1:0] {
      SSAC_IDLE,
      SSAC_WAIT_DELAY,
      SSAC_PRETRIG,
      SSAC_POSTTRIG
   } ssac_state_t;
endpackage

// >>> ssac_sample_source_arm_control.sv
// sample source and arm control register with acquisition sequencing
//
// Contract
// - bits 0-2 select backplane trigger line
// - bit 3 sets line input or output
// - bit 4 enables line; disabled ignored, undriven
// - bit 5 enables internal clock sampling
// - bit 6 picks internal or external timebase
// - bit 7 enables software immediate sample
// - bit 8 picks external sample edge
// - bit 9 enables front-panel sample input
// - abort stops measurement, flushes all memory
// - abort bit clears when acquisition initiates
// - bit 13 arms after 30 ms delay
// - bit 15 arms immediately, clears after pretrigger
// - abort plus arm: abort first, then arm
// - arm after finished measurement: abort then arm
// - all three zero: no action started
// - pretrigger count completion clears arm bits
`timescale 1ns/1ns
`include "ssac_defines.svh"
module ssac_sample_source_arm_control #(
   parameter int unsigned ARM_DELAY_CYCLES = `SSAC_ARM_DELAY_CYC,
   parameter int unsigned COUNT_W          = 22
) (
   // clock, reset, enable
   input  wire logic                     clock,
   input  wire logic                     rst_n,
   input  wire logic                     clk_en,
   // register port, 16-bit word access
   input  wire logic [`SSAC_ADDR_W-1:0]  reg_addr,
   input  wire logic                     reg_write,
   input  wire logic [15:0]              reg_wdata,
   output logic [15:0]                   reg_rdata,
   // acquisition settings from neighbouring registers
   input  wire logic [COUNT_W-1:0]       pretrig_count,
   input  wire logic                     acq_done,
   // sample sources
   input  wire logic                     int_sample_tick,
   input  wire logic                     soft_sample_strobe,
   input  wire logic                     front_sample_pin,
   input  wire logic [7:0]               backplane_trigger_line_in,
   // backplane line drive
   output logic [7:0]                    backplane_trigger_line_out,
   output logic [7:0]                    backplane_trigger_line_oe,
   // controls to the acquisition engine
   output logic                          sample_pulse,
   output logic                          external_timebase_select,
   output logic                          flush_memory,
   output logic                          acq_running
);
   // control register and sequencer state
   ssac_pkg::ssac_ctrl_t ctrl;
   ssac_pkg::ssac_state_t state;
   logic [31:0]          delay_cnt;   // arm delay timer
   logic [COUNT_W-1:0]   pre_cnt;     // readings stored before trigger
   logic [2:0]           front_sync;  // pin synchroniser, stage 0 is the raw catch
   logic                 front_prev;  // last agreed pin level
   logic [2:0]           line_sync [8];
   logic [7:0]           line_prev;
   logic                 wr_hit;
   logic                 wr_abort;
   logic                 wr_arm;
   logic                 start_acq;
   logic                 pre_done;
   logic                 front_edge;
   logic                 line_edge;
   logic [2:0]           sel;

   // write decode
   assign wr_hit   = clk_en && reg_write && (reg_addr == `SSAC_REG_OFFSET);
   assign wr_abort = wr_hit && reg_wdata[`SSAC_BIT_ABORT];
   assign wr_arm   = wr_hit && (reg_wdata[`SSAC_BIT_ARM_NOW] || reg_wdata[`SSAC_BIT_ARM_DELAY]);
   assign sel      = ctrl.line_select;

   // packing helper, used for read back only; reset loads through a cast
   function automatic logic [15:0] ssac_pack(input ssac_pkg::ssac_ctrl_t c);
      logic [15:0] w;
      w = 16'h0000;
      w[`SSAC_BIT_LINE_HI:`SSAC_BIT_LINE_LO] = c.line_select;
      w[`SSAC_BIT_LINE_DIR]  = c.line_drive;
      w[`SSAC_BIT_LINE_EN]   = c.line_enable;
      w[`SSAC_BIT_INT_CLOCK] = c.int_clock_enable;
      w[`SSAC_BIT_EXT_TB]    = c.external_timebase_select;
      w[`SSAC_BIT_SOFT]      = c.soft_sample_enable;
      w[`SSAC_BIT_EDGE]      = c.sample_edge_polarity;
      w[`SSAC_BIT_FRONT_EN]  = c.front_sample_input_enable;
      w[`SSAC_BIT_ABORT]     = c.abort;
      w[`SSAC_BIT_ARM_DELAY] = c.arm_after_delay;
      w[`SSAC_BIT_ARM_NOW]   = c.arm_now;
      return w;
   endfunction

   // edge test for the front pin; the backplane line uses its own rising-edge test
   function automatic logic ssac_edge(input logic prev, input logic now_v, input logic rising);
      return rising ? (!prev && now_v) : (prev && !now_v);
   endfunction

   // a fresh arm only counts when the old acquisition is over
   // arm while running is swallowed so the capture is not torn up
   // an abort in the same write always clears the way for the new arm
   assign start_acq = wr_arm &&
                      (wr_abort || state == ssac_pkg::SSAC_IDLE ||
                       (state == ssac_pkg::SSAC_POSTTRIG && acq_done));
   assign pre_done  = (state == ssac_pkg::SSAC_PRETRIG) && (pre_cnt >= pretrig_count);

   // control register: plain fields stored, action bits handled below
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         ctrl <= ssac_pkg::ssac_ctrl_t'(`SSAC_RESET_VALUE);
      else if (clk_en)
      begin
         if (wr_hit)
         begin
            ctrl.line_select               <= reg_wdata[`SSAC_BIT_LINE_HI:`SSAC_BIT_LINE_LO];
            ctrl.line_drive                <= reg_wdata[`SSAC_BIT_LINE_DIR];
            ctrl.line_enable               <= reg_wdata[`SSAC_BIT_LINE_EN];
            ctrl.int_clock_enable          <= reg_wdata[`SSAC_BIT_INT_CLOCK];
            ctrl.external_timebase_select  <= reg_wdata[`SSAC_BIT_EXT_TB];
            ctrl.soft_sample_enable        <= reg_wdata[`SSAC_BIT_SOFT];
            ctrl.sample_edge_polarity      <= reg_wdata[`SSAC_BIT_EDGE];
            ctrl.front_sample_input_enable <= reg_wdata[`SSAC_BIT_FRONT_EN];
         end
         // abort bit: set by write, cleared once acquisition initiates
         if (start_acq)
            ctrl.abort <= 1'b0;
         else if (wr_abort)
            ctrl.abort <= 1'b1;
         // arm bits: a rejected arm write does not latch; pretrig end clears
         if (start_acq)
         begin
            ctrl.arm_now         <= reg_wdata[`SSAC_BIT_ARM_NOW];
            ctrl.arm_after_delay <= reg_wdata[`SSAC_BIT_ARM_DELAY];
         end
         else if (pre_done || wr_abort)
         begin
            ctrl.arm_now         <= 1'b0;
            ctrl.arm_after_delay <= 1'b0;
         end
      end
   end

   // flush pulse: any abort write, or the abort implied by a fresh arm
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         flush_memory <= 1'b0;
      else if (clk_en)
         flush_memory <= wr_abort || start_acq;
   end

   // acquisition sequencer: flush lands in the same cycle the state leaves idle for pretrig or delay
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state     <= ssac_pkg::SSAC_IDLE;
         delay_cnt <= 32'h00000000;
         pre_cnt   <= '0;
      end
      else if (clk_en)
      begin
         if (start_acq)
         begin
            // abort and arm together: the new arm wins after the flush
            pre_cnt   <= '0;
            delay_cnt <= 32'h00000000;
            state     <= reg_wdata[`SSAC_BIT_ARM_NOW] ? ssac_pkg::SSAC_PRETRIG
                                                      : ssac_pkg::SSAC_WAIT_DELAY;
         end
         else if (wr_abort)
            state <= ssac_pkg::SSAC_IDLE;
         else
         begin
            case (state)
               ssac_pkg::SSAC_IDLE:
                  state <= ssac_pkg::SSAC_IDLE;
               ssac_pkg::SSAC_WAIT_DELAY:
               begin
                  // hold off for the arm delay before storing readings
                  if (delay_cnt >= ARM_DELAY_CYCLES - 1)
                     state <= ssac_pkg::SSAC_PRETRIG;
                  else
                     delay_cnt <= delay_cnt + 32'h00000001;
               end
               ssac_pkg::SSAC_PRETRIG:
               begin
                  if (pre_done)
                     state <= ssac_pkg::SSAC_POSTTRIG;
                  else if (sample_pulse)
                     pre_cnt <= pre_cnt + 1'b1;
               end
               ssac_pkg::SSAC_POSTTRIG:
                  if (acq_done)
                     state <= ssac_pkg::SSAC_IDLE;
               default:
                  state <= ssac_pkg::SSAC_IDLE;
            endcase
         end
      end
   end

   // pin synchronisers; stage 0 feeds only stage 1
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         front_sync <= 3'h0;
         front_prev <= 1'b0;
         // backplane lines idle high, so start there to avoid a false edge
         line_prev  <= 8'hFF;
         for (int i = 0; i < 8; i++)
            line_sync[i] <= 3'h7;
      end
      else if (clk_en)
      begin
         front_sync <= {front_sync[1:0], front_sample_pin};
         // a level counts once stages 1 and 2 agree
         if (front_sync[1] == front_sync[2])
            front_prev <= front_sync[2];
         for (int i = 0; i < 8; i++)
         begin
            line_sync[i] <= {line_sync[i][1:0], backplane_trigger_line_in[i]};
            if (line_sync[i][1] == line_sync[i][2])
               line_prev[i] <= line_sync[i][2];
         end
      end
   end

   // qualified edges; disabled sources are simply ignored
   assign front_edge = ctrl.front_sample_input_enable && (front_sync[1] == front_sync[2]) &&
                       ssac_edge(front_prev, front_sync[2], ctrl.sample_edge_polarity);
   assign line_edge  = ctrl.line_enable && !ctrl.line_drive &&
                       (line_sync[sel][1] == line_sync[sel][2]) &&
                       !line_prev[sel] && line_sync[sel][2];

   // sample pulse merges all enabled pacing sources
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         sample_pulse <= 1'b0;
      else if (clk_en)
         sample_pulse <= (state != ssac_pkg::SSAC_IDLE) && (state != ssac_pkg::SSAC_WAIT_DELAY) &&
                         ((ctrl.int_clock_enable && int_sample_tick) ||
                          (ctrl.soft_sample_enable && soft_sample_strobe) ||
                          front_edge || line_edge);
   end

   // backplane drive: only the selected line, only when enabled as output
   // the line echoes the merged sample pulse so other modules can follow
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         backplane_trigger_line_out <= 8'h00;
         backplane_trigger_line_oe  <= 8'h00;
      end
      else if (clk_en)
      begin
         backplane_trigger_line_oe  <= (ctrl.line_enable && ctrl.line_drive) ?
                                       (8'h01 << sel) : 8'h00;
         backplane_trigger_line_out <= sample_pulse ? (8'h01 << sel) : 8'h00;
      end
   end

   // timebase and run status
   assign external_timebase_select = ctrl.external_timebase_select;
   assign acq_running              = (state != ssac_pkg::SSAC_IDLE);

   // read back: register word, zero elsewhere
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         reg_rdata <= 16'h0000;
      else if (clk_en)
         reg_rdata <= (reg_addr == `SSAC_REG_OFFSET) ? ssac_pack(ctrl) : 16'h0000;
   end

   // a write with no action bits must not flush
   a_no_action_quiet: assert property (@(posedge clock) disable iff (!rst_n)
      (wr_hit && !reg_wdata[12] && !reg_wdata[13] && !reg_wdata[15]) |=> !flush_memory)
      else $error("flush without action bits");
   // abort write flushes next cycle
   a_abort_flush: assert property (@(posedge clock) disable iff (!rst_n)
      wr_abort |=> flush_memory)
      else $error("abort did not flush");
   // initiate clears abort bit
   a_abort_cleared: assert property (@(posedge clock) disable iff (!rst_n)
      start_acq |=> !ctrl.abort)
      else $error("abort bit stayed after initiate");
   // immediate arm goes straight into pretrigger
   a_arm_now_go: assert property (@(posedge clock) disable iff (!rst_n)
      (start_acq && reg_wdata[15]) |=> state == ssac_pkg::SSAC_PRETRIG)
      else $error("immediate arm did not start");
   // delayed arm waits
   a_arm_delay_wait: assert property (@(posedge clock) disable iff (!rst_n)
      (start_acq && !reg_wdata[15]) |=> state == ssac_pkg::SSAC_WAIT_DELAY)
      else $error("delayed arm did not wait");
   // pretrigger completion clears arm bits
   a_pretrig_clear: assert property (@(posedge clock) disable iff (!rst_n)
      (clk_en && pre_done && !wr_arm) |=> (!ctrl.arm_now && !ctrl.arm_after_delay))
      else $error("arm bits not cleared");
   // arm while running is ignored
   a_busy_arm_kept: assert property (@(posedge clock) disable iff (!rst_n)
      (wr_arm && !wr_abort && acq_running &&
       !(state == ssac_pkg::SSAC_POSTTRIG && acq_done)) |=> !flush_memory)
      else $error("running acquisition restarted");
   // disabled line is never driven
   a_line_quiet: assert property (@(posedge clock) disable iff (!rst_n)
      (clk_en && !ctrl.line_enable) |=> backplane_trigger_line_oe == 8'h00)
      else $error("disabled line driven");
endmodule

// >>> ssac_sample_source_arm_control_bench.sv
// self-checking bench for the sample source and arm control register
`timescale 1ns/1ns
module ssac_sample_source_arm_control_bench;
   localparam int DLY = 20;  // shortened arm delay keeps the run brief
   logic        clock;
   logic        rst_n;
   logic        clk_en;   // clock enable, dropped to check the freeze
   logic [5:0]  reg_addr;
   logic        reg_write;
   logic [15:0] reg_wdata;
   logic [15:0] reg_rdata;
   logic [21:0] pretrig_count;
   logic        acq_done;
   logic [1:0]  strobe;  // timer tick, soft sample
   logic        front_pin;
   logic [7:0]  line_in;
   logic [7:0]  line_out;
   logic [7:0]  line_oe;
   logic        sample_pulse;
   logic        ext_tb;
   logic        flush_memory;
   logic        acq_running;
   int          n_mismatch;
   int          checks;
   int          n_samp;   // sample pulses seen
   int          n_flush;  // flush pulses seen
   int          n_drv;    // cycles a line is driven high

   ssac_sample_source_arm_control #(.ARM_DELAY_CYCLES(DLY), .COUNT_W(22))
   i_ssac_sample_source_arm_control (
      .clock(clock), .rst_n(rst_n), .clk_en(clk_en),
      .reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .pretrig_count(pretrig_count), .acq_done(acq_done),
      .int_sample_tick(strobe[0]), .soft_sample_strobe(strobe[1]),
      .front_sample_pin(front_pin), .backplane_trigger_line_in(line_in),
      .backplane_trigger_line_out(line_out), .backplane_trigger_line_oe(line_oe),
      .sample_pulse(sample_pulse), .external_timebase_select(ext_tb),
      .flush_memory(flush_memory), .acq_running(acq_running));

   ssac_partner_model i_ssac_partner_model (
      .line_out(line_out), .line_oe(line_oe),
      .front_pin(front_pin), .line_level(line_in));

   // free-running clock
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // event counters, compared as deltas around each stimulus
   always @(posedge clock)
   begin
      if (sample_pulse === 1'b1) n_samp++;
      if (flush_memory === 1'b1) n_flush++;
      if ((line_out & line_oe) !== 8'h00) n_drv++;
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %0t %s: saw %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      @(negedge clock);
      reg_addr  = a;
      reg_write = 1'b1;
      reg_wdata = d;
      @(negedge clock);
      reg_write = 1'b0;
   endtask

   task automatic rd(input logic [5:0] a, output logic [15:0] d);
      @(negedge clock);
      reg_addr = a;
      @(negedge clock);
      d = reg_rdata;
   endtask

   task automatic fire(input int k);
      @(negedge clock);
      strobe[k] = 1'b1;
      @(negedge clock);
      strobe[k] = 1'b0;
   endtask

   // waits out the pin synchroniser, then compares sample count
   task automatic samp(input int s0, input int exp, input string what);
      repeat (10) @(negedge clock);
      chk(16'(n_samp - s0), 16'(exp), what);
   endtask

   // write, then compare flush pulses and running flag
   task automatic cmd(input logic [15:0] d, input int fl, input logic run);
      int f0;
      f0 = n_flush;
      wr(6'h3E, d);
      repeat (2) @(negedge clock);
      chk(16'(n_flush - f0), 16'(fl), "flush count");
      chk(16'(acq_running), 16'(run), "running flag");
   endtask

   task automatic t_fields();
      logic [15:0] d;
      for (int c = 0; c < 8; c++)
      begin
         wr(6'h3E, 16'h0018 | 16'(c));
         rd(6'h3E, d);
         chk(d, 16'h0018 | 16'(c), "line readback");
         chk(16'(line_oe), 16'h0001 << c, "driven line");
      end
      wr(6'h3E, 16'h0013);
      rd(6'h3E, d);
      chk(16'(line_oe), 16'h0000, "input line undriven");
      wr(6'h3E, 16'h000B);
      rd(6'h3E, d);
      chk(16'(line_oe), 16'h0000, "disabled line undriven");
      wr(6'h3E, 16'h0C40);
      rd(6'h3E, d);
      chk(d, 16'h0040, "reserved bits read zero");
      chk(16'(ext_tb), 16'h0001, "external timebase");
      wr(6'h3C, 16'h0020);
      rd(6'h3C, d);
      chk(d, 16'h0000, "other address");
      rd(6'h3E, d);
      chk(d, 16'h0040, "write elsewhere ignored");
   endtask

   task automatic t_arm_now();
      logic [15:0] d;
      int          s0;
      pretrig_count = 22'h000003;
      cmd(16'h8020, 1, 1'b1);
      rd(6'h3E, d);
      chk(d, 16'h8020, "arm bit set");
      s0 = n_samp;
      repeat (3) fire(0);
      samp(s0, 3, "timer samples");
      rd(6'h3E, d);
      chk(d, 16'h0020, "arm clears after pre-trigger");
      cmd(16'h8020, 0, 1'b1);
      rd(6'h3E, d);
      chk(d, 16'h0020, "arm while running dropped");
      acq_done = 1'b1;
      cmd(16'h8020, 1, 1'b1);
      acq_done = 1'b0;
      cmd(16'h9020, 1, 1'b1);
      rd(6'h3E, d);
      chk(d, 16'h8020, "abort and arm while running");
   endtask

   task automatic t_sources();
      logic [15:0] d;
      pretrig_count = 22'h0003E8;
      cmd(16'h1000, 1, 1'b0);
      rd(6'h3E, d);
      chk(d, 16'h1000, "abort bit reads back");
      cmd(16'h9395, 1, 1'b1);
      rd(6'h3E, d);
      chk(d, 16'h8395, "abort bit cleared");
      fire(0);
      samp(n_samp, 0, "timer disabled");
      fire(1);
      samp(n_samp, 1, "soft sample");
      i_ssac_partner_model.set_front(1'b1);
      samp(n_samp, 1, "rising edge");
      i_ssac_partner_model.set_front(1'b0);
      samp(n_samp, 0, "falling ignored");
      i_ssac_partner_model.line_pulse(5);
      samp(n_samp, 1, "selected line");
      i_ssac_partner_model.line_pulse(4);
      samp(n_samp, 0, "other line");
      cmd(16'h0225, 0, 1'b1);
      fire(1);
      samp(n_samp, 0, "soft disabled");
      fire(0);
      samp(n_samp, 1, "timer enabled");
      i_ssac_partner_model.set_front(1'b1);
      samp(n_samp, 0, "rising ignored");
      i_ssac_partner_model.set_front(1'b0);
      samp(n_samp, 1, "falling edge");
      i_ssac_partner_model.line_pulse(5);
      samp(n_samp, 0, "line disabled");
      wr(6'h3E, 16'h003D);
      d = 16'(n_drv);
      fire(0);
      samp(n_samp, 1, "timer with line out");
      chk(16'(n_drv) - d, 16'h0001, "line driven out");
      i_ssac_partner_model.set_front(1'b1);
      samp(n_samp, 0, "front disabled");
      cmd(16'h1000, 1, 1'b0);
   endtask

   task automatic t_delay();
      logic [15:0] d;
      pretrig_count = 22'h000001;
      cmd(16'h2020, 1, 1'b1);
      fire(0);
      samp(n_samp, 0, "no sample in delay");
      repeat (DLY) @(negedge clock);
      fire(0);
      samp(n_samp, 1, "sample after delay");
      rd(6'h3E, d);
      chk(d, 16'h0020, "delayed arm clears");
   endtask

   // clock enable low: writes, strobes and flushes must all be frozen
   task automatic t_hold();
      logic [15:0] d;
      int          f0;
      f0 = n_flush;
      @(negedge clock);
      clk_en = 1'b0;
      wr(6'h3E, 16'h9020);
      fire(0);
      samp(n_samp, 0, "no sample while frozen");
      chk(16'(n_flush - f0), 16'h0000, "no flush while frozen");
      @(negedge clock);
      clk_en = 1'b1;
      rd(6'h3E, d);
      chk(d, 16'h0020, "write ignored while frozen");
   endtask

   task automatic conclude();
      $display("mismatches %0d of %0d checks", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // main sequence, inputs change at the falling edge
   initial
   begin
      logic [15:0] d;
      n_mismatch    = 0;
      checks        = 0;
      rst_n         = 1'b0;
      clk_en        = 1'b1;
      reg_addr      = 6'h00;
      reg_write     = 1'b0;
      reg_wdata     = 16'h0000;
      pretrig_count = 22'h000000;
      acq_done      = 1'b0;
      strobe        = 2'b00;
      repeat (12) @(negedge clock);
      rst_n = 1'b1;
      rd(6'h3E, d);
      chk(d, 16'h0000, "reset value");
      t_fields();
      t_arm_now();
      t_sources();
      t_delay();
      t_hold();
      conclude();
   end

   // hang guard, far beyond the few hundred cycles the tests need
   initial
   begin
      #200000;
      n_mismatch++;
      $display("[FAIL] %0t watchdog expired", $time);
      conclude();
   end
endmodule
